// File: hdl/scc_pkg.sv
// scc_pkg: constants and carrier types for the sample convert control block
// assumes a single 20 MHz system clock shared by every user of the package
package scc_pkg;
    // clock rate
    localparam int unsigned CLK_PERIOD_NS = 50;
    // conversion time, longest, rounds down
    localparam int unsigned CONV_MAX_NS   = 725;
    localparam int unsigned CONV_CYC      = CONV_MAX_NS / CLK_PERIOD_NS;
    // acquisition window at 1 MSPS, least, rounds up
    localparam int unsigned ACQ_MIN_NS    = 465;
    localparam int unsigned ACQ_CYC       =
        (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // hold time of the internal power-on reset
    localparam int unsigned POR_NS        = 1000;
    localparam int unsigned POR_CYC       = POR_NS / CLK_PERIOD_NS;
    // settle wait after the end of reset, in microseconds
    localparam int unsigned SETTLE_US     = 1000;
    localparam int unsigned SETTLE_CYC    = SETTLE_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 16;
    localparam int unsigned NUM_CH        = 8;
    // reference control reset values: bandgap and buffer enabled
    localparam logic        REF_BG_RST    = 1'b1;
    localparam logic        REF_BUF_RST   = 1'b1;

    typedef enum logic [1:0] {
        SCC_RESET,
        SCC_IDLE,
        SCC_CONVERT
    } scc_state_type;

    // reference configuration carrier
    typedef struct packed {
        logic bandgap_en;
        logic buffer_en;
    } scc_ref_type;

    // sequencer state of the block; settle timer and edge history are kept outside
    typedef struct packed {
        scc_state_type     state;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  acq_cnt;
        logic              busy;
        logic              hold;
        logic              acq_ok;
        logic              pd_seen;
        logic              conv_since_pd;
        logic              sampled;
        scc_ref_type       ref_cfg;
    } scc_core_type;
endpackage

// File: hdl/scc_sync.sv
// scc_sync: two-flop synchroniser for a group of asynchronous pins
// assumes the destination runs on i_sys_clk
`timescale 1ns/100ps
`default_nettype none
module scc_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst_n,
    // pins and synchronised copy
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    // first stage is read only by the second stage
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: hdl/scc_top.sv
// scc_top: convert-start sequencing, busy, internal reset and reference mode
// assumes convert_start and powerdown_pin are asynchronous pins; supply
// monitors arrive as active-high level pins; reference control is a plain pin
//
// Notes on behaviour
// - rising convert_start holds all eight channels together and starts converting
// - a started conversion always completes; only reset aborts it
// - busy rises at conversion start and falls when it finishes
// - each conversion finishes within 725 ns of internal clock
// - acquisition window of at least 465 ns is provided at 1 MSPS
// - acquisition of next sample overlaps the end of conversion
// - full reset at power-up or low core supplies; reinit when good
// - busy falling ends reset; host waits 1 ms before converting
// - after reset bandgap feeds internal buffer by default
// - powerdown_pin raised twice without conversion gives a global reset
`timescale 1ns/100ps
`default_nettype none
module scc_top
    import scc_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    // host pins
    input  wire logic              i_convert_start,
    input  wire logic              i_powerdown_pin,
    // supply monitors, high while supply in range
    input  wire logic              i_core_supply_ok,
    input  wire logic              i_low_supply_ok,
    // reference control from the device control register
    input  wire logic              i_ref_bg_dis,
    input  wire logic              i_ref_buf_dis,
    // status outputs
    output logic                   o_busy,
    output logic [NUM_CH-1:0]      o_hold,
    output logic                   o_acq_ok,
    output logic                   o_settled,
    output logic                   o_sample_strobe,
    output logic                   o_bandgap_en,
    output logic                   o_buffer_en
);
    logic [3:0]   pins_s;
    logic         cnv_s;
    logic         cnv_d_r;
    logic         pd_d_r;
    logic         supplies_ok;
    logic         cnv_rise;
    logic         pd_rise;
    logic [CNT_W-1:0] settle_r;
    logic         strobe_r;
    logic         settled_r;
    scc_core_type core_r;
    scc_core_type core_nxt;

    scc_sync #(
        .W (4)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_async   ({i_convert_start, i_powerdown_pin,
                     i_core_supply_ok, i_low_supply_ok}),
        .o_sync    (pins_s)
    );

    assign cnv_s       = pins_s[3];
    assign supplies_ok = pins_s[1] & pins_s[0];
    assign cnv_rise    = cnv_s & ~cnv_d_r;
    assign pd_rise     = pins_s[2] & ~pd_d_r;

    // edge history registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cnv_d_r <= 1'b0;
            pd_d_r  <= 1'b0;
        end else begin
            cnv_d_r <= cnv_s;
            pd_d_r  <= pins_s[2];
        end
    end

    // next-state logic of the sequencer
    always_comb begin
        core_nxt = core_r;
        core_nxt.sampled = 1'b0;
        if (core_r.acq_cnt != '0) begin
            core_nxt.acq_cnt = core_r.acq_cnt - 1'b1;
        end
        core_nxt.acq_ok = (core_r.acq_cnt <= CNT_W'(1)) && !core_r.hold;
        if (pd_rise) begin
            core_nxt.pd_seen       = 1'b1;
            core_nxt.conv_since_pd = 1'b0;
        end
        if (!supplies_ok || (pd_rise && core_r.pd_seen
                             && !core_r.conv_since_pd)) begin
            core_nxt.state   = SCC_RESET;
            core_nxt.cnt     = CNT_W'(POR_CYC);
            core_nxt.busy    = 1'b1;
            core_nxt.hold    = 1'b0;
            core_nxt.pd_seen = 1'b0;
            core_nxt.ref_cfg = '{bandgap_en: REF_BG_RST,
                                 buffer_en:  REF_BUF_RST};
        end else begin
            unique case (core_r.state)
                SCC_RESET: begin
                    if (core_r.cnt == '0) begin
                        // busy falls at end of reset
                        core_nxt.busy  = 1'b0;
                        core_nxt.state = SCC_IDLE;
                    end else begin
                        core_nxt.cnt = core_r.cnt - 1'b1;
                    end
                end
                SCC_IDLE: begin
                    core_nxt.ref_cfg = '{bandgap_en: !i_ref_bg_dis,
                                         buffer_en:  !i_ref_buf_dis};
                    if (cnv_rise) begin
                        core_nxt.state         = SCC_CONVERT;
                        core_nxt.cnt           = CNT_W'(CONV_CYC - 1);
                        core_nxt.busy          = 1'b1;
                        core_nxt.hold          = 1'b1;
                        core_nxt.sampled       = 1'b1;
                        core_nxt.conv_since_pd = 1'b1;
                        // a powerdown edge in the same cycle sets pd_seen, but with conv_since_pd set it does not count
                        core_nxt.pd_seen       = pd_rise;
                        core_nxt.acq_ok        = 1'b0;
                    end
                end
                SCC_CONVERT: begin
                    // release hold early so acquisition overlaps
                    if (core_r.cnt == CNT_W'(2)) begin
                        core_nxt.hold    = 1'b0;
                        core_nxt.acq_cnt = CNT_W'(ACQ_CYC);
                    end
                    if (core_r.cnt == '0) begin
                        core_nxt.busy  = 1'b0;
                        core_nxt.state = SCC_IDLE;
                    end else begin
                        core_nxt.cnt = core_r.cnt - 1'b1;
                    end
                end
                // unused state code falls back into internal reset
                default: begin
                    core_nxt.state = SCC_RESET;
                    core_nxt.cnt   = CNT_W'(POR_CYC);
                    core_nxt.busy  = 1'b1;
                    core_nxt.hold  = 1'b0;
                end
            endcase
        end
    end

    // state register and settle timer
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            core_r   <= '{state: SCC_RESET, cnt: CNT_W'(POR_CYC),
                          acq_cnt: '0, busy: 1'b1, hold: 1'b0,
                          acq_ok: 1'b0, pd_seen: 1'b0,
                          conv_since_pd: 1'b0, sampled: 1'b0,
                          ref_cfg: '{bandgap_en: REF_BG_RST,
                                     buffer_en:  REF_BUF_RST}};
            settle_r  <= '0;
            strobe_r  <= 1'b0;
            settled_r <= 1'b0;
        end else begin
            core_r    <= core_nxt;
            strobe_r  <= core_nxt.sampled;
            // registered so the output comes straight from a flop
            settled_r <= (settle_r == '0) && (core_r.state != SCC_RESET);
            if (core_r.state == SCC_RESET) begin
                settle_r <= CNT_W'(SETTLE_CYCLES);
            end else if (settle_r != '0) begin
                settle_r <= settle_r - 1'b1;
            end
        end
    end

    assign o_busy          = core_r.busy;
    assign o_hold          = {NUM_CH{core_r.hold}};
    assign o_acq_ok        = core_r.acq_ok;
    assign o_settled       = settled_r;
    assign o_sample_strobe = strobe_r;
    assign o_bandgap_en    = core_r.ref_cfg.bandgap_en;
    assign o_buffer_en     = core_r.ref_cfg.buffer_en;

    // assertion helpers
    property p_busy_len;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (core_r.state == SCC_IDLE && core_nxt.state == SCC_CONVERT) |=>
        o_busy [*8] ##0 (core_r.state == SCC_CONVERT);
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy dropped early");

    property p_conv_bound;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ($rose(core_r.state == SCC_CONVERT) && supplies_ok)
        |-> ##[1:14] (!o_busy || core_r.state == SCC_RESET);
    endproperty
    a_conv_bound: assert property (p_conv_bound)
        else $error("conversion exceeded bound");

    property p_hold_start;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        $rose(core_r.state == SCC_CONVERT) |-> (o_hold == '1) && o_busy;
    endproperty
    a_hold_start: assert property (p_hold_start)
        else $error("hold not taken at start");

    property p_no_restart;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (core_r.state == SCC_CONVERT && core_r.cnt != '0 && supplies_ok
         && !pd_rise) |=> (core_r.cnt == $past(core_r.cnt) - 1'b1);
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("conversion restarted");

    property p_overlap;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        $fell(core_r.hold) && core_r.state == SCC_CONVERT |-> o_busy;
    endproperty
    a_overlap: assert property (p_overlap)
        else $error("no acquisition overlap");

    property p_acq;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        $fell(core_r.hold) |-> !o_acq_ok [*8];
    endproperty
    a_acq: assert property (p_acq)
        else $error("acquisition window too short");

    property p_supply_reset;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !supplies_ok |=> o_busy && core_r.state == SCC_RESET;
    endproperty
    a_supply_reset: assert property (p_supply_reset)
        else $error("supply drop did not reset");

    property p_ref_default;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        core_r.state == SCC_RESET |-> o_bandgap_en && o_buffer_en;
    endproperty
    a_ref_default: assert property (p_ref_default)
        else $error("reference not default in reset");

    property p_settle;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        $fell(o_busy) && $past(core_r.state) == SCC_RESET |-> !o_settled;
    endproperty
    a_settle: assert property (p_settle)
        else $error("settled too soon");

    c_conv: cover property (@(posedge i_sys_clk) $fell(o_busy)
                            && $past(core_r.state) == SCC_CONVERT);
    c_por: cover property (@(posedge i_sys_clk) $rose(o_settled));
    c_pd2: cover property (@(posedge i_sys_clk) pd_rise && core_r.pd_seen);
endmodule
`default_nettype wire

// File: testbench/scc_host_model.sv
// scc_host_model: host controller that pulses convert_start on request
// assumes the bench asks only after settled; slow mode holds until busy drops
`timescale 1ns/100ps
`default_nettype none
module scc_host_model (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    // bench request and mode
    input  wire logic i_go,
    input  wire logic i_slow,
    // device status
    input  wire logic i_busy,
    input  wire logic i_settled,
    // convert pin
    output logic      o_convert_start
);
    logic busy_d_r;
    logic cvt_r;

    // pin is registered so it moves only just after a clock edge
    assign o_convert_start = cvt_r;

    // pulse width, settle wait, quiet lines
    // no data lines are driven, so nothing toggles before the rise
    always_ff @(posedge i_sys_clk) begin
        busy_d_r <= i_busy;
        if (!i_rst_n) begin
            cvt_r <= 1'b0;
        end else if (i_go && i_settled) begin
            cvt_r <= 1'b1;
        end else if (!i_slow || (busy_d_r && !i_busy)) begin
            cvt_r <= 1'b0; // one cycle is 50 ns, or held past busy fall
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_sample_convert_control.sv
// tb_sample_convert_control: self-checking bench for scc_top
// assumes the host model drives convert_start; other pins driven here
`timescale 1ns/100ps
`default_nettype none
module tb_sample_convert_control
    import scc_pkg::*;
();
    localparam int SETTLE = 50; // shortened settle wait
    logic       sys_clk = 1'b0, rst_n = 1'b0, go = 1'b0, slow = 1'b0;
    logic       pd = 1'b0, core_ok = 1'b1, low_ok = 1'b1;
    logic       bg_dis = 1'b0, buf_dis = 1'b0, cvt, busy, acq_ok;
    logic       settled, strobe, bg_en, buf_en;
    logic [7:0] hold;
    int         n_errors = 0;
    int         num_checks = 0;

    // clock, 50 ns period
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // device and host
    scc_top #(.SETTLE_CYCLES(SETTLE)) i_dut (.i_sys_clk(sys_clk),
        .i_rst_n(rst_n), .i_convert_start(cvt), .i_powerdown_pin(pd),
        .i_core_supply_ok(core_ok), .i_low_supply_ok(low_ok),
        .i_ref_bg_dis(bg_dis), .i_ref_buf_dis(buf_dis), .o_busy(busy),
        .o_hold(hold), .o_acq_ok(acq_ok), .o_settled(settled),
        .o_sample_strobe(strobe), .o_bandgap_en(bg_en),
        .o_buffer_en(buf_en));
    scc_host_model i_host (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
        .i_go(go), .i_slow(slow), .i_busy(busy), .i_settled(settled),
        .o_convert_start(cvt));

    task automatic check_lvl(input string what, input logic [7:0] exp,
                             input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // cycle counts are bench integers, so a plain compare is enough
    task automatic check_cnt(input string what, input int lo, input int hi,
                             input int got);
        num_checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi,
                     got);
        end
    endtask

    // bounded wait for busy low, or for settled high
    task automatic count_to(input bit want_settled, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (n < 300 && (want_settled ? settled !== 1'b1
                                            : busy !== 1'b0));
    endtask

    task automatic t_reset();
        int n;
        repeat (6) @(posedge sys_clk);
        #1;
        check_lvl("busy_rst", 8'h01, 8'(busy));
        check_lvl("hold_rst", 8'h00, hold);
        check_lvl("bg_rst", 8'h01, 8'(bg_en));
        check_lvl("buf_rst", 8'h01, 8'(buf_en));
        check_lvl("settled_rst", 8'h00, 8'(settled));
        @(posedge sys_clk) rst_n <= 1'b1;
        count_to(1'b0, n);
        check_cnt("por_len", POR_CYC, POR_CYC + 4, n);
        check_lvl("settled_early", 8'h00, 8'(settled));
        count_to(1'b1, n);
        check_cnt("settle_len", SETTLE, SETTLE + 2, n);
        $display("test reset done");
    endtask

    task automatic t_ref();
        @(posedge sys_clk) bg_dis <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        check_lvl("bg_off", 8'h00, 8'(bg_en));
        check_lvl("buf_kept", 8'h01, 8'(buf_en));
        @(posedge sys_clk) buf_dis <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        check_lvl("buf_off", 8'h00, 8'(buf_en));
        @(posedge sys_clk) {bg_dis, buf_dis} <= 2'b00;
        repeat (4) @(posedge sys_clk);
        #1;
        check_lvl("ref_back", 8'h03, {6'b0, bg_en, buf_en});
        $display("test reference done");
    endtask

    // one request, optional second rise while busy; timings in cycles
    task automatic t_conv(input bit slow_mode, input bit twice,
                          input string name);
        int tb, te, thf, tac, nst;
        logic [7:0] hv;
        {tb, te, thf, tac, nst} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1, 32'd0};
        hv = 8'h00;
        @(posedge sys_clk) begin
            slow <= slow_mode;
            go <= 1'b1;
        end
        for (int c = 1; c <= 60; c++) begin
            @(posedge sys_clk) go <= twice && c == 6;
            #1;
            if (busy === 1'b1 && tb < 0) {tb, hv} = {c, hold};
            if (tb >= 0 && busy === 1'b0 && te < 0) te = c;
            if (tb >= 0 && hold === 8'h00 && thf < 0) thf = c;
            if (thf >= 0 && acq_ok === 1'b1 && tac < 0) tac = c;
            if (strobe === 1'b1) nst++;
        end
        check_cnt("start_lat", 3, 3, tb - 1);
        check_lvl("hold_all", 8'hff, hv);
        check_cnt("busy_len", CONV_CYC, CONV_CYC, te - tb);
        check_cnt("busy_ns", 0, CONV_MAX_NS, (te - tb) * CLK_PERIOD_NS);
        check_cnt("overlap", 1, 4, te - thf);
        check_cnt("acq_len", ACQ_CYC, ACQ_CYC + 1, tac - thf);
        check_cnt("strobes", 1, 1, nst);
        $display("test %s done", name);
    endtask

    task automatic t_powerdown();
        int n;
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk) pd <= (k % 2 == 0);
            repeat (3) @(posedge sys_clk);
        end
        #1;
        check_lvl("pd_busy", 8'h01, 8'(busy));
        check_lvl("pd_unsettled", 8'h00, 8'(settled));
        count_to(1'b0, n);
        count_to(1'b1, n);
        check_cnt("pd_settle", SETTLE, SETTLE + 2, n);
        $display("test powerdown done");
    endtask

    task automatic t_supply();
        int n;
        for (int s = 0; s < 2; s++) begin
            @(posedge sys_clk) {core_ok, low_ok} <= s ? 2'b10 : 2'b01;
            repeat (6) @(posedge sys_clk);
            #1;
            check_lvl("supply_busy", 8'h01, 8'(busy));
            @(posedge sys_clk) {core_ok, low_ok} <= 2'b11;
            count_to(1'b0, n);
            check_cnt("supply_por", POR_CYC, POR_CYC + 4, n);
            count_to(1'b1, n);
        end
        $display("test supply done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        t_reset();
        t_ref();
        t_conv(1'b0, 1'b0, "prompt");
        t_conv(1'b1, 1'b0, "slow");
        t_conv(1'b0, 1'b1, "second_rise");
        t_powerdown();
        t_supply();
        t_conv(1'b0, 1'b0, "after_reinit");
        end_of_test();
    end

    // watchdog well past the roughly 600 cycles the tests need
    initial begin
        #(CLK_PERIOD_NS * 6000);
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
